/* File: sca_stat_counter_access.sv */
// Behaviour
// - Each port owns control/status and data registers.
// - Reading a counter clears it to zero.
// - Index and go accepted together or separately.
// - Bit 25 clears when count valid; software polls.
// - Count in data register; bits 35:32 in control.
// - Overflow flag shown in control/status register.
// - Bit 24 enrols port in freeze and flush.
// - One switch register freezes/flushes all enrolled ports.
// - Value 0x40 freezes and holds enrolled counters.
// - Value 0xC0 clears enrolled counters, keeps frozen.
// - Value 0x00 releases; enrolled counters count again.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module sca_stat_counter_access #(
  parameter int NUM_PORTS = 6
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 stat_event_valid,
  input  wire logic [3:0]           stat_event_port,
  input  wire logic [7:0]           stat_event_index,
  input  wire logic [31:0]          stat_event_amount,
  output logic                      irq
);

  localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
  localparam logic [NUM_PORTS-1:0] ONE = {{(NUM_PORTS-1){1'b0}}, 1'b1};

  // ****************************************************************
  // State
  // ****************************************************************
  logic [35:0]          cnt_mem [NUM_PORTS][sca_pkg::SCA_NUM_SLOTS];
  logic                 ovf_mem [NUM_PORTS][sca_pkg::SCA_NUM_SLOTS];
  logic [7:0]           stat_counter_select [NUM_PORTS];
  logic [31:0]          port_stat_count_value [NUM_PORTS];
  logic [3:0]           hi_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] ovf_reg;
  logic [NUM_PORTS-1:0] stat_read_go_done;
  logic [NUM_PORTS-1:0] port_freeze_flush_en;
  logic [7:0]           switch_stat_freeze_flush_ctrl;
  logic [NUM_PORTS-1:0] int_stat_reg;
  logic [NUM_PORTS-1:0] int_mask_reg;
  sca_pkg::sca_state_t  st_reg;
  logic [PW-1:0]        fp_reg;
  logic [5:0]           fslot_reg;
  logic                 fvalid_reg;
  logic [11:0]          aw_addr_reg;
  logic [31:0]          w_data_reg;
  logic [3:0]           w_strb_reg;
  logic                 aw_full_reg;
  logic                 w_full_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [1:0]           rresp_reg;
  logic [31:0]          rdata_reg;

  function automatic logic port_ok(input logic [11:0] a);
    return (a[11:8] == sca_pkg::SCA_PORT_PAGE) && (int'(a[7:4]) < NUM_PORTS) &&
           ((a[3:0] == sca_pkg::SCA_OFF_CS) || (a[3:0] == sca_pkg::SCA_OFF_DATA));
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    return port_ok(a) || (a == sca_pkg::SCA_OFF_SW_CTRL) ||
           (a == sca_pkg::SCA_OFF_INT_STAT) || (a == sca_pkg::SCA_OFF_INT_MASK);
  endfunction

  function automatic logic [PW-1:0] first_set(input logic [NUM_PORTS-1:0] v);
    logic [PW-1:0] r;
    r = '0;
    for (int i = NUM_PORTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PW'(i);
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Freeze/flush control and event path
  // ****************************************************************
  wire              freeze_on = switch_stat_freeze_flush_ctrl[sca_pkg::SCA_BIT_FREEZE];
  wire              flush_on  = switch_stat_freeze_flush_ctrl[sca_pkg::SCA_BIT_FLUSH];
  wire              ev_ok     = stat_event_valid && (int'(stat_event_port) < NUM_PORTS) &&
                                sca_pkg::sca_idx_ok(stat_event_index);
  wire [PW-1:0]     ev_ps     = ev_ok ? stat_event_port[PW-1:0] : '0;
  wire [5:0]        ev_slot   = sca_pkg::sca_slot_of(stat_event_index);
  wire              ev_enr    = port_freeze_flush_en[ev_ps];
  wire              ev_go     = ev_ok && !(ev_enr && (freeze_on || flush_on));
  wire              fetch_clr = (st_reg == sca_pkg::SCA_FETCH) && fvalid_reg;
  wire              ev_clash  = fetch_clr && (fp_reg == ev_ps) && (fslot_reg == ev_slot);
  wire [35:0]       ev_cur    = cnt_mem[ev_ps][ev_slot];
  // Only the two byte counters are 36 bits wide; the drop counters above them are narrow.
  wire              ev_wide   = (ev_slot >= sca_pkg::SCA_HI_SLOT0) &&
                                (ev_slot <= sca_pkg::SCA_WIDE_LAST);
  // An event racing a read-clear lands on zero, so it is counted after the read.
  wire [36:0]       ev_sum    = sca_pkg::sca_cnt_add(ev_clash ? 36'h0 : ev_cur,
                                                     stat_event_amount, ev_wide);
  wire              ev_ovf    = ev_sum[36] | (!ev_clash && ovf_mem[ev_ps][ev_slot]);
  wire [35:0]       fetch_val = cnt_mem[fp_reg][fslot_reg];
  wire              fetch_ovf = ovf_mem[fp_reg][fslot_reg];

  always_ff @(posedge clk or negedge resetn) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int s = 0; s < sca_pkg::SCA_NUM_SLOTS; s++) begin
        if (!resetn) begin
          cnt_mem[p][s] <= '0;
          ovf_mem[p][s] <= 1'b0;
        end else if (flush_on && port_freeze_flush_en[p]) begin
          cnt_mem[p][s] <= '0;
          ovf_mem[p][s] <= 1'b0;
        end else if (ev_go && (ev_ps == PW'(p)) && (ev_slot == 6'(s))) begin
          cnt_mem[p][s] <= ev_sum[35:0];
          ovf_mem[p][s] <= ev_ovf;
        end else if (fetch_clr && (fp_reg == PW'(p)) && (fslot_reg == 6'(s))) begin
          cnt_mem[p][s] <= '0;
          ovf_mem[p][s] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Fetch sequencer
  // ****************************************************************
  wire [PW-1:0]        pick     = first_set(stat_read_go_done);
  wire [7:0]           pick_idx = stat_counter_select[pick];
  wire [NUM_PORTS-1:0] done_vec = (st_reg == sca_pkg::SCA_DONE) ? (ONE << fp_reg) : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg     <= sca_pkg::SCA_IDLE;
      fp_reg     <= '0;
      fslot_reg  <= '0;
      fvalid_reg <= 1'b0;
    end else begin
      case (st_reg)
        sca_pkg::SCA_IDLE: begin
          if (|stat_read_go_done) begin
            st_reg     <= sca_pkg::SCA_FETCH;
            fp_reg     <= pick;
            fslot_reg  <= sca_pkg::sca_slot_of(pick_idx);
            fvalid_reg <= sca_pkg::sca_idx_ok(pick_idx);
          end
        end
        sca_pkg::SCA_FETCH: begin
          st_reg <= sca_pkg::SCA_DONE;
        end
        sca_pkg::SCA_DONE: begin
          st_reg <= sca_pkg::SCA_IDLE;
        end
        default: begin
          st_reg <= sca_pkg::SCA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!resetn) begin
        port_stat_count_value[p] <= '0;
        hi_reg[p]                <= '0;
        ovf_reg[p]               <= 1'b0;
      end else if ((st_reg == sca_pkg::SCA_FETCH) && (fp_reg == PW'(p))) begin
        port_stat_count_value[p] <= fvalid_reg ? fetch_val[31:0] : '0;
        hi_reg[p]                <= fvalid_reg ? fetch_val[35:32] : '0;
        ovf_reg[p]               <= fvalid_reg && fetch_ovf;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  wire                 wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  wire                 wr_cs   = wr_fire && port_ok(aw_addr_reg) &&
                                 (aw_addr_reg[3:0] == sca_pkg::SCA_OFF_CS);
  wire [NUM_PORTS-1:0] cs_wr   = wr_cs ? (ONE << aw_addr_reg[7:4]) : '0;
  wire                 ctl_wr  = wr_fire && (aw_addr_reg == sca_pkg::SCA_OFF_SW_CTRL) &&
                                 w_strb_reg[0];
  wire                 ist_wr  = wr_fire && (aw_addr_reg == sca_pkg::SCA_OFF_INT_STAT) &&
                                 w_strb_reg[0];
  wire                 msk_wr  = wr_fire && (aw_addr_reg == sca_pkg::SCA_OFF_INT_MASK) &&
                                 w_strb_reg[0];
  wire [NUM_PORTS-1:0] w1c     = ist_wr ? w_data_reg[NUM_PORTS-1:0] : '0;
  wire                 go_w    = w_strb_reg[3] && w_data_reg[sca_pkg::SCA_BIT_GO];
  wire [PW-1:0]        rd_p    = port_ok(s_axi_araddr) ? s_axi_araddr[PW+3:4] : '0;
  wire [31:0]          cs_val  = {ovf_reg[rd_p], 5'h00, stat_read_go_done[rd_p],
                                  port_freeze_flush_en[rd_p], stat_counter_select[rd_p],
                                  12'h000, hi_reg[rd_p]};
  logic [31:0]         rd_val;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq           = |(int_stat_reg & int_mask_reg);

  always_comb begin
    rd_val = '0;
    if (port_ok(s_axi_araddr)) begin
      rd_val = (s_axi_araddr[3:0] == sca_pkg::SCA_OFF_CS) ? cs_val :
               port_stat_count_value[rd_p];
    end else if (s_axi_araddr == sca_pkg::SCA_OFF_SW_CTRL) begin
      rd_val = {24'h000000, switch_stat_freeze_flush_ctrl};
    end else if (s_axi_araddr == sca_pkg::SCA_OFF_INT_STAT) begin
      rd_val = 32'(int_stat_reg);
    end else if (s_axi_araddr == sca_pkg::SCA_OFF_INT_MASK) begin
      rd_val = 32'(int_mask_reg);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= sca_pkg::SCA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_ok(aw_addr_reg) ? sca_pkg::SCA_RESP_OKAY : sca_pkg::SCA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= sca_pkg::SCA_RESP_OKAY;
      rdata_reg  <= '0;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_val;
      rresp_reg  <= addr_ok(s_axi_araddr) ? sca_pkg::SCA_RESP_OKAY : sca_pkg::SCA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Register fields and interrupts
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switch_stat_freeze_flush_ctrl <= sca_pkg::SCA_SW_CTRL_RST;
      int_stat_reg                  <= '0;
      int_mask_reg                  <= '0;
    end else begin
      if (ctl_wr) begin
        switch_stat_freeze_flush_ctrl <= w_data_reg[7:0];
      end
      if (msk_wr) begin
        int_mask_reg <= w_data_reg[NUM_PORTS-1:0];
      end
      int_stat_reg <= (int_stat_reg & ~w1c) | done_vec;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!resetn) begin
        stat_counter_select[p]  <= '0;
        port_freeze_flush_en[p] <= 1'b0;
        stat_read_go_done[p]    <= 1'b0;
      end else begin
        if (cs_wr[p] && w_strb_reg[2]) begin
          stat_counter_select[p] <= w_data_reg[sca_pkg::SCA_IDX_LSB +: 8];
        end
        if (cs_wr[p] && w_strb_reg[3]) begin
          port_freeze_flush_en[p] <= w_data_reg[sca_pkg::SCA_BIT_FFEN];
        end
        if (cs_wr[p] && go_w) begin
          stat_read_go_done[p] <= 1'b1;
        end else if (done_vec[p]) begin
          stat_read_go_done[p] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [PW-1:0] evp_q;
  logic [5:0]    evs_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evp_q <= '0;
      evs_q <= '0;
    end else begin
      evp_q <= ev_ps;
      evs_q <= ev_slot;
    end
  end

  wire [35:0] ev_q_val = cnt_mem[evp_q][evs_q];
  wire        ev_q_ovf = ovf_mem[evp_q][evs_q];

  sequence s_go_raised;
    $rose(stat_read_go_done[0]) && !(st_reg == sca_pkg::SCA_DONE && fp_reg == '0);
  endsequence
  sequence s_go_served;
    ##[1:8] (st_reg == sca_pkg::SCA_DONE && fp_reg == '0) ##1 !stat_read_go_done[0];
  endsequence
  property p_go_done;
    @(posedge clk) disable iff (!resetn) s_go_raised |-> s_go_served;
  endproperty
  a_go_done: assert property (p_go_done) else $error("read go bit not cleared");

  property p_read_clear;
    @(posedge clk) disable iff (!resetn)
      fetch_clr && !(ev_go && ev_ps == fp_reg && ev_slot == fslot_reg) |=>
      (fetch_val == 36'h0) && !fetch_ovf;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("counter not cleared on read");

  property p_data_low;
    @(posedge clk) disable iff (!resetn)
      fetch_clr |=> port_stat_count_value[fp_reg] == $past(fetch_val[31:0]);
  endproperty
  a_data_low: assert property (p_data_low) else $error("count low word wrong");

  property p_data_high;
    @(posedge clk) disable iff (!resetn)
      fetch_clr |=> hi_reg[fp_reg] == $past(fetch_val[35:32]);
  endproperty
  a_data_high: assert property (p_data_high) else $error("count high bits wrong");

  property p_ovf_report;
    @(posedge clk) disable iff (!resetn)
      fetch_clr |=> ovf_reg[fp_reg] == $past(fetch_ovf);
  endproperty
  a_ovf_report: assert property (p_ovf_report) else $error("overflow not reported");

  property p_freeze_hold;
    @(posedge clk) disable iff (!resetn)
      ev_ok && ev_enr && freeze_on && !flush_on && !ev_clash |=> ev_q_val == $past(ev_cur);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("frozen counter moved");

  property p_flush_zero;
    @(posedge clk) disable iff (!resetn)
      flush_on && ev_ok && ev_enr |=> ev_q_val == 36'h0 && !ev_q_ovf;
  endproperty
  a_flush_zero: assert property (p_flush_zero) else $error("flush left a count");

  property p_unenrolled_runs;
    @(posedge clk) disable iff (!resetn)
      ev_ok && !ev_enr && (freeze_on || flush_on) && !ev_clash |=>
      ev_q_val == $past(ev_sum[35:0]);
  endproperty
  a_unenrolled_runs: assert property (p_unenrolled_runs) else $error("idle port stopped");

  property p_released_runs;
    @(posedge clk) disable iff (!resetn)
      ev_ok && !freeze_on && !flush_on && !ev_clash |=> ev_q_val == $past(ev_sum[35:0]);
  endproperty
  a_released_runs: assert property (p_released_runs) else $error("counter not counting");

  property p_wrap_flag;
    @(posedge clk) disable iff (!resetn)
      ev_go && ev_sum[36] && !flush_on |=> ev_q_ovf;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap not flagged");

endmodule

`default_nettype wire

/* File: sca_pkg.sv */
`default_nettype none

package sca_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam logic [11:0] SCA_OFF_SW_CTRL  = 12'h000;
  localparam logic [11:0] SCA_OFF_INT_STAT = 12'h004;
  localparam logic [11:0] SCA_OFF_INT_MASK = 12'h008;
  localparam logic [3:0]  SCA_PORT_PAGE    = 4'h1;
  localparam logic [3:0]  SCA_OFF_CS       = 4'h0;
  localparam logic [3:0]  SCA_OFF_DATA     = 4'h4;

  localparam int SCA_BIT_OVF    = 31;
  localparam int SCA_BIT_GO     = 25;
  localparam int SCA_BIT_FFEN   = 24;
  localparam int SCA_IDX_LSB    = 16;
  localparam int SCA_BIT_FLUSH  = 7;
  localparam int SCA_BIT_FREEZE = 6;

  localparam logic [7:0] SCA_SW_CTRL_RST = 8'h00;
  localparam logic [1:0] SCA_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SCA_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Counter slots
  // ****************************************************************
  localparam int         SCA_NUM_SLOTS = 36;
  localparam int         SCA_NARROW_W  = 30;
  localparam logic [7:0] SCA_WIDE_BASE = 8'h80;
  localparam logic [5:0] SCA_HI_SLOT0  = 6'h20;
  localparam logic [5:0] SCA_WIDE_LAST = 6'h21;

  typedef enum logic [1:0] {
    SCA_IDLE  = 2'h0,
    SCA_FETCH = 2'h1,
    SCA_DONE  = 2'h3
  } sca_state_t;

  function automatic logic sca_idx_ok(input logic [7:0] idx);
    return (idx[7:5] == 3'h0) || (idx[7:2] == SCA_WIDE_BASE[7:2]);
  endfunction

  function automatic logic [5:0] sca_slot_of(input logic [7:0] idx);
    return idx[7] ? (SCA_HI_SLOT0 | {4'h0, idx[1:0]}) : {1'b0, idx[4:0]};
  endfunction

  // Returns the carry-out above the counter's own width and the new value.
  function automatic logic [36:0] sca_cnt_add(input logic [35:0] v,
                                              input logic [31:0] a,
                                              input logic        wide);
    logic [36:0] s;
    s = {1'b0, v} + {5'h00, a};
    if (wide) begin
      return s;
    end
    return {|s[36:SCA_NARROW_W], 6'h00, s[SCA_NARROW_W-1:0]};
  endfunction

endpackage

`default_nettype wire

/* File: sca_stat_counter_access_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end

module sca_stat_counter_access_tb;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, eamt, v;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  eidx, ctrl;
  logic [3:0]  eport, ws, wsel;
  logic        clk, resetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, ev_v, irq;
  logic [15:0] lf;
  logic [7:0]  idxs[5];
  int          fail_count, num_checks, k, p, j;
  longint      m[6][256];
  bit          ov[6][256];
  bit          ffen[6];

  sca_stat_counter_access #(.NUM_PORTS(6)) dut (.clk(clk), .resetn(resetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .stat_event_valid(ev_v), .stat_event_port(eport),
    .stat_event_index(eidx), .stat_event_amount(eamt), .irq(irq));

  // ****************************************************************
  // Clock, helpers and bus tasks
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [11:0] reg_a(input int pn, input logic [3:0] off);
    return {sca_pkg::SCA_PORT_PAGE, 4'(pn), off};
  endfunction

  task automatic axi_w(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    awa <= a; wd <= d; ws <= wsel; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrdy) wv <= 1'h0;
      if (bv === 1'h1) begin rs = bresp; done = 1; end
    end
    br <= 1'h0;
  endtask

  task automatic axi_r(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    ara <= a; arv <= 1'h1; rr <= 1'h1;
    while (!done) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'h0;
      if (rv === 1'h1) begin d = rdat; rs = rresp; done = 1; end
    end
    rr <= 1'h0;
  endtask

  task automatic sw(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] rs;
    axi_w(a, d, rs);
    `CHK("bresp", sca_pkg::SCA_RESP_OKAY, rs)
  endtask

  // One counted event, mirrored into the reference counts.
  task automatic ev(input int pn, input logic [7:0] i, input logic [31:0] a);
    longint s, lim;
    @(posedge clk);
    ev_v <= 1'h1; eport <= 4'(pn); eidx <= i; eamt <= a;
    @(posedge clk);
    ev_v <= 1'h0;
    if (pn < 6 && !(ffen[pn] && ctrl[7:6] != 2'h0)) begin
      lim = (i == 8'h80 || i == 8'h81) ? 64'h10_0000_0000 : 64'h4000_0000;
      s = m[pn][i] + a;
      if (s >= lim) begin ov[pn][i] = 1; s -= lim; end
      m[pn][i] = s;
    end
  endtask

  task automatic rdcnt(input int pn, input logic [7:0] i, input bit split);
    logic [31:0] cmd, d;
    logic [1:0]  rs;
    int          n;
    cmd = {7'h00, 1'(ffen[pn]), i, 16'h0000};
    if (split) sw(reg_a(pn, sca_pkg::SCA_OFF_CS), cmd);
    // A split start writes only the top byte lane, so the index must survive from before.
    if (split) wsel = 4'h8;
    sw(reg_a(pn, sca_pkg::SCA_OFF_CS), cmd | 32'h0200_0000);
    wsel = 4'hf;
    n = 0;
    do begin axi_r(reg_a(pn, sca_pkg::SCA_OFF_CS), d, rs); n++; end
    while (d[25] !== 1'h0 && n < 50);
    `CHK("go", 1'h0, d[25])
    `CHK("cs_hi", 4'(m[pn][i] >> 32), d[3:0])
    `CHK("cs_ovf", 1'(ov[pn][i]), d[31])
    `CHK("cs_en", 1'(ffen[pn]), d[24])
    axi_r(reg_a(pn, sca_pkg::SCA_OFF_DATA), d, rs);
    `CHK("count", 32'(m[pn][i]), d)
    `CHK("rresp", sca_pkg::SCA_RESP_OKAY, rs)
    m[pn][i] = 0;
    ov[pn][i] = 0;
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    give_verdict;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn = 1'h0; awv = 1'h0; wv = 1'h0; br = 1'h0; arv = 1'h0; rr = 1'h0; ev_v = 1'h0;
    awa = 12'h000; ara = 12'h000; wd = 32'h0; eport = 4'h0; eidx = 8'h00; eamt = 32'h0;
    lf = 16'h0049; ctrl = 8'h00; fail_count = 0; num_checks = 0;
    ws = 4'hf; wsel = 4'hf;
    idxs = '{8'h00, 8'h05, 8'h1f, 8'h82, 8'h83};
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    axi_r(12'h000, v, r);
    `CHK("ctrl_rst", 32'h0, v)
    axi_r(12'hffc, v, r);
    `CHK("unmapped", sca_pkg::SCA_RESP_SLVERR, r)
    `CHK("unmapped_d", 32'h0, v)
    for (k = 0; k < 60; k++) begin
      lf = lfsr_step(lf);
      ev(int'(lf[2:0]), idxs[lf[5:3] % 5], {28'h0, lf[9:6]} + 32'h1);
    end
    for (p = 0; p < 6; p++)
      for (j = 0; j < 5; j++) rdcnt(p, idxs[j], j[0]);
    ev(0, 8'h05, 32'h9);
    rdcnt(0, 8'h05, 1'h0);
    rdcnt(0, 8'h05, 1'h0);
    repeat (20) ev(0, 8'h81, 32'hffff_fff0);
    rdcnt(0, 8'h81, 1'h0);
    repeat (2) ev(3, 8'h06, 32'h3fff_0000);
    rdcnt(3, 8'h06, 1'h1);
    rdcnt(3, 8'h06, 1'h0);
    repeat (2) ev(4, 8'h82, 32'h3fff_ffff);
    rdcnt(4, 8'h82, 1'h1);
    #1;
    `CHK("irq_masked", 1'h0, irq)
    sw(12'h008, 32'h1);
    #1;
    `CHK("irq_on", 1'h1, irq)
    sw(12'h004, 32'h3f);
    #1;
    `CHK("irq_off", 1'h0, irq)
    ffen[1] = 1;
    sw(reg_a(1, sca_pkg::SCA_OFF_CS), 32'h0100_0000);
    ev(1, 8'h02, 32'h5);
    ev(2, 8'h02, 32'h5);
    ctrl = 8'h40;
    sw(12'h000, 32'h40);
    axi_r(12'h000, v, r);
    `CHK("ctrl", 32'h40, v)
    ev(1, 8'h02, 32'h7);
    ev(2, 8'h02, 32'h7);
    ctrl = 8'hc0;
    sw(12'h000, 32'hc0);
    for (k = 0; k < 256; k++) begin
      m[1][k] = 0;
      ov[1][k] = 0;
    end
    ev(1, 8'h02, 32'h9);
    ev(2, 8'h02, 32'h9);
    ctrl = 8'h00;
    sw(12'h000, 32'h0);
    ev(1, 8'h02, 32'h3);
    ev(2, 8'h02, 32'h3);
    ctrl = 8'h40;
    sw(12'h000, 32'h40);
    ev(1, 8'h02, 32'h4);
    rdcnt(1, 8'h02, 1'h0);
    rdcnt(2, 8'h02, 1'h0);
    give_verdict;
  end
endmodule

`default_nettype wire
